// >>> verilog/odcr_pkg.sv
package odcr_pkg;

  // Register offsets within the page
  localparam logic [7:0] OFS_PROGRAM_COMMAND_CTRL         = 8'h0F;
  localparam logic [7:0] OFS_OUT1_DIVIDE_RATIO_HIGH       = 8'h18;
  localparam logic [7:0] OFS_OUT1_DIVIDE_RATIO_MID        = 8'h19;
  localparam logic [7:0] OFS_OUT1_DIVIDE_RATIO_LOW        = 8'h1A;
  localparam logic [7:0] OFS_OUT1_DRIVER_PHASE_STRENGTH   = 8'h1B;
  localparam logic [7:0] OFS_OUT1_OUTPUT_DELAY            = 8'h1C;
  localparam logic [7:0] OFS_OUT1_DRIVER_STANDARD_SUPPLY  = 8'h1D;
  localparam logic [7:0] OFS_SHADOW_FIRST                 = 8'h18;
  localparam logic [7:0] OFS_SHADOW_LAST                  = 8'h67;
  localparam logic [7:0] OFS_PAGE_SELECT                  = 8'hFF;
  localparam logic [7:0] THIS_PAGE                        = 8'h03;
  localparam int         SHADOW_DEPTH                     = 80;

  // Field positions
  localparam int CMD_MSB        = 7;
  localparam int CMD_LSB        = 3;
  localparam int ESCAPE_BIT     = 1;
  localparam int DIV_HIGH_MSB   = 3;
  localparam int PHASE_MSB      = 7;
  localparam int PHASE_LSB      = 6;
  localparam int STRENGTH_MSB   = 2;
  localparam int COARSE_MSB     = 5;
  localparam int FINE_MSB       = 7;
  localparam int FINE_LSB       = 6;
  localparam int SUPPLY_MSB     = 4;
  localparam int SUPPLY_LSB     = 3;
  localparam int STANDARD_MSB   = 2;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int         FINE_STEP_PS = 30;

  // Program command codes
  localparam logic [4:0] CMD_FUSE_BURN     = 5'h18;
  localparam logic [4:0] CMD_FUSE_READ     = 5'h0C;
  localparam logic [4:0] CMD_COPY_SHADOW   = 5'h06;
  localparam logic [4:0] CMD_GO_ACTIVE     = 5'h1B;

  // Supply levels
  localparam logic [1:0] SUPPLY_1V8 = 2'h0;
  localparam logic [1:0] SUPPLY_2V5 = 2'h1;
  localparam logic [1:0] SUPPLY_3V3 = 2'h2;

  typedef enum logic [2:0] {
    STD_LVDS         = 3'h0,
    STD_LVPECL_CM    = 3'h1,
    STD_CML_DC       = 3'h2,
    STD_HCSL_DC      = 3'h3,
    STD_LVDS_BOOST   = 3'h4,
    STD_LVPECL_NOCM  = 3'h5
  } odcr_std_t;

  // Live settings handed to the output channel
  typedef struct packed {
    logic [19:0] output_divide_ratio;
    logic        cmos_pin_positive_inv;
    logic        cmos_pin_negative_inv;
    logic [2:0]  drive_strength;
    logic [5:0]  coarse_delay_cycles;
    logic [1:0]  fine_delay_steps;
    logic [1:0]  output_supply_level;
    logic [2:0]  output_driver_standard;
    logic        standard_valid;
  } odcr_live_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } odcr_req_t;

endpackage : odcr_pkg

// >>> verilog/odcr_regs.sv
`timescale 1ns/1ns
`default_nettype none
module odcr_regs
  import odcr_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       clk_en,
  input  wire odcr_req_t  req,
  output var  logic [7:0] rdata_ff,
  output var  logic       rvalid_ff,
  output var  logic       active_ff,
  output var  logic       fuse_burn_ff,
  output var  logic       fuse_read_ff,
  output var  odcr_live_t live_ff
);

  typedef enum logic [0:0] {ST_COMMAND, ST_ACTIVE} odcr_state_t;

  odcr_state_t state_ff;
  logic [7:0]  page_ff;
  logic [7:0]  command_ff;
  logic [7:0]  shadow_ff [SHADOW_DEPTH];
  odcr_state_t nxt_state;

  function automatic logic in_shadow(input logic [7:0] a);
    in_shadow = (a >= OFS_SHADOW_FIRST) && (a <= OFS_SHADOW_LAST);
  endfunction : in_shadow

  // Only meaningful while in_shadow holds; the subtraction wraps below the window
  function automatic logic [6:0] shadow_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - OFS_SHADOW_FIRST;
    shadow_idx = d[6:0];
  endfunction : shadow_idx

  function automatic logic [7:0] sh(input logic [7:0] a);
    sh = shadow_ff[shadow_idx(a)];
  endfunction : sh

  logic       on_page;
  logic       wr_cmd;
  logic [4:0] code;
  assign on_page = (page_ff == THIS_PAGE);
  assign wr_cmd  = req.wr && on_page && (req.addr == OFS_PROGRAM_COMMAND_CTRL);
  assign code    = req.wdata[CMD_MSB:CMD_LSB];

  // Shadow bytes that feed the live settings at a copy command
  logic [7:0] sh_div_high;
  logic [7:0] sh_div_mid;
  logic [7:0] sh_div_low;
  logic [7:0] sh_phase_strength;
  logic [7:0] sh_delay;
  logic [7:0] sh_std_supply;
  assign sh_div_high       = shadow_ff[shadow_idx(OFS_OUT1_DIVIDE_RATIO_HIGH)];
  assign sh_div_mid        = shadow_ff[shadow_idx(OFS_OUT1_DIVIDE_RATIO_MID)];
  assign sh_div_low        = shadow_ff[shadow_idx(OFS_OUT1_DIVIDE_RATIO_LOW)];
  assign sh_phase_strength = shadow_ff[shadow_idx(OFS_OUT1_DRIVER_PHASE_STRENGTH)];
  assign sh_delay          = shadow_ff[shadow_idx(OFS_OUT1_OUTPUT_DELAY)];
  assign sh_std_supply     = shadow_ff[shadow_idx(OFS_OUT1_DRIVER_STANDARD_SUPPLY)];

  // Command codes act only in the command-accepting state
  function automatic logic cmd_is(input logic [4:0] want);
    cmd_is = wr_cmd && (state_ff == ST_COMMAND) && (code == want);
  endfunction : cmd_is

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      page_ff <= REG_RESET;
    end else if (clk_en && req.wr && req.addr == OFS_PAGE_SELECT) begin
      page_ff <= req.wdata;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      command_ff <= REG_RESET;
    end else if (clk_en && wr_cmd) begin
      command_ff <= req.wdata;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < SHADOW_DEPTH; i++) begin
        shadow_ff[i] <= REG_RESET;
      end
    end else if (clk_en && req.wr && on_page && in_shadow(req.addr)) begin
      shadow_ff[shadow_idx(req.addr)] <= req.wdata;
    end
  end

  // Device state machine: next state decoded once, state and its flag registered
  // Codes written while active are ignored; only the escape bit counts there
  always_comb begin
    nxt_state = state_ff;
    if (wr_cmd) begin
      unique case (state_ff)
        ST_COMMAND: begin
          if (code == CMD_GO_ACTIVE) begin
            nxt_state = ST_ACTIVE;
          end
        end
        ST_ACTIVE: begin
          if (req.wdata[ESCAPE_BIT]) begin
            nxt_state = ST_COMMAND;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_ff  <= ST_COMMAND;
      active_ff <= 1'b0;
    end else if (clk_en) begin
      state_ff  <= nxt_state;
      active_ff <= (nxt_state == ST_ACTIVE);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fuse_burn_ff <= 1'b0;
    end else if (clk_en) begin
      fuse_burn_ff <= cmd_is(CMD_FUSE_BURN);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fuse_read_ff <= 1'b0;
    end else if (clk_en) begin
      fuse_read_ff <= cmd_is(CMD_FUSE_READ);
    end
  end

  // copy shadow to live settings; other codes leave them alone
  // Live settings move only here, so half-written shadow bytes never reach the driver
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      live_ff <= '0;
    end else if (clk_en && cmd_is(CMD_COPY_SHADOW)) begin
      // divide ratio assembly, spare high nibble dropped
      live_ff.output_divide_ratio <= {sh_div_high[DIV_HIGH_MSB:0],
                                      sh_div_mid,
                                      sh_div_low};
      live_ff.cmos_pin_positive_inv <= sh_phase_strength[PHASE_MSB];
      live_ff.cmos_pin_negative_inv <=
        (sh_phase_strength[PHASE_MSB:PHASE_LSB] != 2'h1);
      live_ff.drive_strength <= sh_phase_strength[STRENGTH_MSB:0];
      live_ff.coarse_delay_cycles <= sh_delay[COARSE_MSB:0];
      live_ff.fine_delay_steps <= sh_delay[FINE_MSB:FINE_LSB];
      live_ff.output_supply_level <=
        sh_std_supply[SUPPLY_MSB:SUPPLY_LSB];
      live_ff.output_driver_standard <= sh_std_supply[STANDARD_MSB:0];
      live_ff.standard_valid <= (sh_std_supply[STANDARD_MSB:0]
                                 <= STD_LVPECL_NOCM);
    end
  end

  // Read strobe answered one cycle later
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rvalid_ff <= 1'b0;
    end else if (clk_en) begin
      rvalid_ff <= req.rd;
    end
  end

  // Read port: one cycle latency
  // A write and a read in the same cycle: the read returns the old value
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_ff  <= REG_RESET;
    end else if (clk_en) begin
      if (!req.rd) begin
        rdata_ff <= REG_RESET;
      end else if (req.addr == OFS_PAGE_SELECT) begin
        rdata_ff <= page_ff;
      end else if (on_page && req.addr == OFS_PROGRAM_COMMAND_CTRL) begin
        rdata_ff <= command_ff;
      end else if (on_page && in_shadow(req.addr)) begin
        rdata_ff <= sh(req.addr);
      end else begin
        rdata_ff <= REG_RESET;
      end
    end
  end

endmodule : odcr_regs
`default_nettype wire

// >>> test/odcr_props.sv
`timescale 1ns/1ns
`default_nettype none
module odcr_props
  import odcr_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       clk_en,
  input wire odcr_req_t  req,
  input wire logic [7:0] rdata_ff,
  input wire logic       rvalid_ff,
  input wire logic       active_ff,
  input wire logic       fuse_burn_ff,
  input wire logic       fuse_read_ff,
  input wire odcr_live_t live_ff
);
  logic [7:0] pg_ff;
  logic       ca;
  logic       cw;
  logic [4:0] cd;
  assign ca = clk_en && req.wr && req.addr == 8'h0F && pg_ff == 8'h03;
  assign cw = ca && !active_ff;
  assign cd = req.wdata[7:3];
  // Page tracker
  always_ff @(posedge clock or posedge rst) begin
    if (rst) pg_ff <= 8'h00;
    else if (clk_en && req.wr && req.addr == 8'hFF) pg_ff <= req.wdata;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_page; clk_en && req.rd && req.addr == 8'hFF |=> rdata_ff == $past(pg_ff); endproperty
  a_page: assert property (p_page) else $error("page readback");
  property p_burn; cw && cd == 5'h18 |=> fuse_burn_ff && !fuse_read_ff; endproperty
  a_burn: assert property (p_burn) else $error("no burn pulse");
  property p_fread; cw && cd == 5'h0C |=> fuse_read_ff && !fuse_burn_ff; endproperty
  a_fread: assert property (p_fread) else $error("no read pulse");
  property p_go; cw && cd == 5'h1B |=> active_ff; endproperty
  a_go: assert property (p_go) else $error("not active");
  property p_esc; ca && active_ff && req.wdata[1] |=> !active_ff; endproperty
  a_esc: assert property (p_esc) else $error("no escape");
  property p_odd; cw && !(cd inside {5'h18, 5'h0C, 5'h06, 5'h1B}) |=>
    !fuse_burn_ff && !fuse_read_ff && !active_ff; endproperty
  a_odd: assert property (p_odd) else $error("odd code acted");
  property p_live; !(cw && cd == 5'h06) |=> $stable(live_ff); endproperty
  a_live: assert property (p_live) else $error("live changed");
  property p_rst; $fell(rst) |-> live_ff == '0 && !active_ff && rdata_ff == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("reset value");
endmodule : odcr_props
bind odcr_regs odcr_props u_props (.clock, .rst, .clk_en, .req, .rdata_ff, .rvalid_ff,
  .active_ff, .fuse_burn_ff, .fuse_read_ff, .live_ff);
`default_nettype wire

// >>> test/odcr_host.sv
`timescale 1ns/1ns
`default_nettype none
module odcr_host
  import odcr_pkg::*;
(
  input wire logic      clock,
  output var odcr_req_t req
);
  initial req = '0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge clock);
    // Released lines show junk
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : xfer
endmodule : odcr_host
`default_nettype wire

// >>> test/test_output_divider_config_regs.sv
`timescale 1ns/1ns
`default_nettype none
module test_output_divider_config_regs
  import odcr_pkg::*;
();
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        clk_en = 1'b1;
  odcr_req_t   req;
  logic [7:0]  rdata_ff;
  logic        rvalid_ff;
  logic        active_ff;
  logic        fuse_burn_ff;
  logic        fuse_read_ff;
  odcr_live_t  live_ff;
  logic [7:0]  sh [24:29];
  logic [31:0] seed = 32'h0000_9C49;
  int          err_total = 0;
  int          checked = 0;
  odcr_host host (.clock(clock), .req(req));
  odcr_regs dut (.clock(clock), .rst(rst), .clk_en(clk_en), .req(req), .rdata_ff(rdata_ff),
    .rvalid_ff(rvalid_ff), .active_ff(active_ff), .fuse_burn_ff(fuse_burn_ff),
    .fuse_read_ff(fuse_read_ff), .live_ff(live_ff));
  initial forever #4 clock = ~clock;
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  function automatic odcr_live_t exp_live();
    odcr_live_t e;
    e = {sh[24][3:0], sh[25], sh[26], sh[27][7], sh[27][7:6] != 2'h1, sh[27][2:0],
      sh[28][5:0], sh[28][7:6], sh[29][4:0], sh[29][2:0] <= 3'h5};
    return e;
  endfunction : exp_live
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic chk_live(input odcr_live_t e, input odcr_live_t s);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH live exp %h got %h", e, s);
    end
  endtask : chk_live
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    host.xfer(1'b0, a, 8'h00);
    chk("rvalid", 8'h01, {7'h0, rvalid_ff});
    chk("rdata", e, rdata_ff);
  endtask : rd
  task automatic print_verdict();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (3000) @(posedge clock);
    err_total++;
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    host.xfer(1'b1, 8'hFF, 8'h03);
    rd(8'hFF, 8'h03);
    for (int a = 24; a < 30; a++) rd(8'(a), 8'h00);
    for (int i = 0; i < 8; i++) begin
      for (int a = 24; a < 30; a++) sh[a] = rnd();
      sh[27][7:6] = i[1:0];
      sh[29][2:0] = i[2:0];
      if (i == 7) sh[27][2:0] = 3'h7;
      for (int a = 24; a < 30; a++) host.xfer(1'b1, 8'(a), sh[a]);
      rd(8'h1C, sh[28]);
      host.xfer(1'b1, 8'h0F, 8'h30);
      chk_live(exp_live(), live_ff);
    end
    host.xfer(1'b1, 8'h67, 8'hA5);
    rd(8'h67, 8'hA5);
    host.xfer(1'b1, 8'h68, 8'h5A);
    rd(8'h68, 8'h00);
    host.xfer(1'b1, 8'h0F, 8'hC0);
    chk("burn", 8'h01, {6'h0, fuse_read_ff, fuse_burn_ff});
    host.xfer(1'b1, 8'h0F, 8'h60);
    chk("fread", 8'h02, {6'h0, fuse_read_ff, fuse_burn_ff});
    host.xfer(1'b1, 8'h0F, 8'hF8);
    chk("odd", 8'h00, {5'h0, active_ff, fuse_read_ff, fuse_burn_ff});
    host.xfer(1'b1, 8'h0F, 8'hD8);
    chk("go", 8'h04, {5'h0, active_ff, fuse_read_ff, fuse_burn_ff});
    host.xfer(1'b1, 8'h0F, 8'hC0);
    chk("act", 8'h04, {5'h0, active_ff, fuse_read_ff, fuse_burn_ff});
    host.xfer(1'b1, 8'h0F, 8'h02);
    chk("esc", 8'h00, {7'h0, active_ff});
    host.xfer(1'b1, 8'hFF, 8'h01);
    host.xfer(1'b1, 8'h0F, 8'hD8);
    chk("offpage", 8'h00, {7'h0, active_ff});
    rd(8'h1C, 8'h00);
    @(negedge clock);
    clk_en = 1'b0;
    host.xfer(1'b1, 8'hFF, 8'h03);
    clk_en = 1'b1;
    rd(8'hFF, 8'h01);
    rst = 1'b1;
    @(negedge clock);
    rst = 1'b0;
    rd(8'hFF, 8'h00);
    print_verdict();
  end
endmodule : test_output_divider_config_regs
`default_nettype wire
